// file: hw/vrtc_defines.svh
`ifndef VRTC_DEFINES_SVH
`define VRTC_DEFINES_SVH

// register byte addresses
`define VRTC_CTRL_ADDR        12'h000
`define VRTC_STAT_ADDR        12'h004
`define VRTC_ADDR_W           12

// control register field positions
`define VRTC_REF_EN_BIT       7
`define VRTC_READY_BIT        6
`define VRTC_TS_EN_BIT        5
`define VRTC_TS_RNG_BIT       4
`define VRTC_CMP_GAIN_HI      3
`define VRTC_CMP_GAIN_LO      2
`define VRTC_CONV_GAIN_HI     1
`define VRTC_CONV_GAIN_LO     0
`define VRTC_CTRL_RESET       8'h00

// status register field positions
`define VRTC_ST_CONV_SETTLED  0
`define VRTC_ST_CMP_SETTLED   1
`define VRTC_ST_TS_SETTLED    2

// timing
`define VRTC_CLK_PERIOD_NS    4
`define VRTC_BUF_SETTLE_NS    30000
`define VRTC_TS_SETTLE_NS     200000
`define VRTC_TIMER_W          16

`endif

// file: hw/vrtc_pkg.sv
package vrtc_pkg;

  typedef enum logic [1:0] {
    VRTC_GAIN_OFF = 2'b00,
    VRTC_GAIN_1X  = 2'b01,
    VRTC_GAIN_2X  = 2'b10,
    VRTC_GAIN_4X  = 2'b11
  } vrtc_gain_e;

  typedef enum logic [1:0] {
    VRTC_PH_IDLE   = 2'b00,
    VRTC_PH_ACCESS = 2'b01,
    VRTC_PH_DONE   = 2'b10
  } vrtc_phase_e;

endpackage

// file: hw/vrtc_sync.sv
`timescale 1ns/10ps
module vrtc_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // vrtc_sync

// file: hw/vrtc_top.sv
// Contract
// [RULE1] control bit 7 turns the fixed reference on when 1 and off when 0.
// [RULE2] control bit 6 is a read-only ready flag, 1 only when the reference is usable.
// [RULE3] on the standard-voltage variant the ready flag always reads 1.
// [RULE4] control bit 5 powers the temperature sensing circuit when set.
// [RULE5] control bit 4 selects high range (four drops) when 1, low range (two) when 0.
// [RULE6] bits 3-2 set the comparator/DAC gain: 11 4x, 10 2x, 01 1x, 00 off.
// [RULE7] bits 1-0 set the converter gain with the same encoding.
// [RULE8] every writable control bit clears to zero on every reset.
// [RULE9] the temperature output is routed to its own converter input channel.
// [RULE10] software waits 200 us after selecting that channel before converting.
// [RULE11] software spaces temperature conversions at least 200 us apart.
// [RULE12] software waits 30 us after enabling a buffer output before using it.
// [RULE13] writes to the ready flag position are ignored.
`timescale 1ns/10ps
`include "vrtc_defines.svh"
module vrtc_top #(
  parameter bit                        STANDARD_VARIANT = 1'b0,
  parameter logic [`VRTC_TIMER_W-1:0]  BUF_SETTLE_CYCLES =
    `VRTC_TIMER_W'((`VRTC_BUF_SETTLE_NS + `VRTC_CLK_PERIOD_NS - 1)
                   / `VRTC_CLK_PERIOD_NS),
  parameter logic [`VRTC_TIMER_W-1:0]  TS_SETTLE_CYCLES =
    `VRTC_TIMER_W'((`VRTC_TS_SETTLE_NS + `VRTC_CLK_PERIOD_NS - 1)
                   / `VRTC_CLK_PERIOD_NS)
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`VRTC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    ref_stable,
  output logic                         ref_enable,
  output logic [1:0]                   cmp_dac_ref_gain,
  output logic [1:0]                   converter_ref_gain,
  output logic                         temp_sense_enable,
  output logic                         temp_range_select,
  output logic                         temp_channel_route
);

  logic [7:0]               ctrl;
  logic                     ref_stable_sync;
  logic                     reference_ready_flag;
  logic [`VRTC_TIMER_W-1:0] conv_timer;
  logic [`VRTC_TIMER_W-1:0] cmp_timer;
  logic [`VRTC_TIMER_W-1:0] ts_timer;
  logic                     conv_settled;
  logic                     cmp_settled;
  logic                     ts_settled;
  logic                     access;
  logic                     complete;
  logic                     hit_ctrl;
  logic                     hit_stat;
  logic [31:0]              next_prdata;
  logic [7:0]               next_ctrl;

  // analog ready comes from another domain
  vrtc_sync u_ready_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ref_stable),
    .sync_out (ref_stable_sync)
  );

  function automatic logic [`VRTC_TIMER_W-1:0] settle_step(
    input logic                     active,
    input logic [`VRTC_TIMER_W-1:0] count,
    input logic [`VRTC_TIMER_W-1:0] limit
  );
    if (!active)
      settle_step = '0;
    else if (count < limit)
      settle_step = count + `VRTC_TIMER_W'(1);
    else
      settle_step = count;
  endfunction

  // except on the standard-voltage variant, flag is low while disabled, whatever the analog side says
  assign reference_ready_flag = STANDARD_VARIANT ? 1'b1 :         // [RULE3]
                                (ctrl[`VRTC_REF_EN_BIT] &         // [RULE2]
                                 ref_stable_sync);

  assign access   = psel && penable;
  assign complete = access && pready;
  assign hit_ctrl = (paddr == `VRTC_CTRL_ADDR);
  assign hit_stat = (paddr == `VRTC_STAT_ADDR);

  always_comb begin
    next_ctrl = ctrl;
    if (complete && pwrite && hit_ctrl && pstrb[0]) begin
      next_ctrl[`VRTC_REF_EN_BIT] = pwdata[`VRTC_REF_EN_BIT];     // [RULE1]
      next_ctrl[`VRTC_TS_EN_BIT]  = pwdata[`VRTC_TS_EN_BIT];      // [RULE4]
      next_ctrl[`VRTC_TS_RNG_BIT] = pwdata[`VRTC_TS_RNG_BIT];     // [RULE5]
      next_ctrl[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO] =
        pwdata[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO];               // [RULE6]
      next_ctrl[`VRTC_CONV_GAIN_HI:`VRTC_CONV_GAIN_LO] =
        pwdata[`VRTC_CONV_GAIN_HI:`VRTC_CONV_GAIN_LO];             // [RULE7]
    end
    next_ctrl[`VRTC_READY_BIT] = 1'b0;                            // [RULE13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `VRTC_CTRL_RESET;                                   // [RULE8]
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && !pready && !hit_ctrl && !hit_stat;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata[7:0] = ctrl;
      next_prdata[`VRTC_READY_BIT] = reference_ready_flag;        // [RULE2]
    end else if (hit_stat) begin
      next_prdata[`VRTC_ST_CONV_SETTLED] = conv_settled;
      next_prdata[`VRTC_ST_CMP_SETTLED]  = cmp_settled;
      next_prdata[`VRTC_ST_TS_SETTLED]   = ts_settled;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= next_prdata;
    end else if (!access) begin
      prdata <= 32'h0000_0000;
    end
  end

  // buffer settle timers restart whenever a path is switched off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_timer <= '0;
      cmp_timer  <= '0;
    end else begin
      conv_timer <= settle_step(ctrl[`VRTC_REF_EN_BIT] &&
                      (ctrl[`VRTC_CONV_GAIN_HI:`VRTC_CONV_GAIN_LO] !=
                       vrtc_pkg::VRTC_GAIN_OFF),
                      conv_timer, BUF_SETTLE_CYCLES);              // [RULE12]
      cmp_timer  <= settle_step(ctrl[`VRTC_REF_EN_BIT] &&
                      (ctrl[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO] !=
                       vrtc_pkg::VRTC_GAIN_OFF),
                      cmp_timer, BUF_SETTLE_CYCLES);               // [RULE12]
    end
  end

  // advisory only: software still owns conversion spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_timer <= '0;
    end else begin
      ts_timer <= settle_step(ctrl[`VRTC_TS_EN_BIT], ts_timer,
                              TS_SETTLE_CYCLES);                   // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_settled <= 1'b0;
      cmp_settled  <= 1'b0;
      ts_settled   <= 1'b0;
    end else begin
      conv_settled <= (conv_timer >= BUF_SETTLE_CYCLES);
      cmp_settled  <= (cmp_timer >= BUF_SETTLE_CYCLES);
      ts_settled   <= (ts_timer >= TS_SETTLE_CYCLES);
    end
  end

  // analog controls, each straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_enable         <= 1'b0;
      cmp_dac_ref_gain   <= vrtc_pkg::VRTC_GAIN_OFF;
      converter_ref_gain <= vrtc_pkg::VRTC_GAIN_OFF;
      temp_sense_enable  <= 1'b0;
      temp_range_select  <= 1'b0;
      temp_channel_route <= 1'b0;
    end else begin
      ref_enable         <= next_ctrl[`VRTC_REF_EN_BIT];           // [RULE1]
      cmp_dac_ref_gain   <=
        next_ctrl[`VRTC_CMP_GAIN_HI:`VRTC_CMP_GAIN_LO];            // [RULE6]
      converter_ref_gain <=
        next_ctrl[`VRTC_CONV_GAIN_HI:`VRTC_CONV_GAIN_LO];          // [RULE7]
      temp_sense_enable  <= next_ctrl[`VRTC_TS_EN_BIT];            // [RULE4]
      temp_range_select  <= next_ctrl[`VRTC_TS_RNG_BIT];           // [RULE5]
      temp_channel_route <= next_ctrl[`VRTC_TS_EN_BIT];            // [RULE9]
    end
  end

endmodule // vrtc_top

// file: verification/vrtc_analog_model.sv
`timescale 1ns/10ps
module vrtc_analog_model #(
  parameter int LAG = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ref_enable,
  output logic      ref_stable
);
  int cnt;
  // settles LAG cycles after enable, collapses at once when switched off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else cnt <= ref_enable ? (cnt < LAG ? cnt + 1 : cnt) : 0;
  end
  assign ref_stable = ref_enable && cnt >= LAG;
endmodule // vrtc_analog_model

// file: verification/vrtc_properties.sv
`timescale 1ns/10ps
module vrtc_checker #(
  parameter bit STANDARD_VARIANT = 1'b0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        ref_enable,
  input wire logic [1:0]  cmp_dac_ref_gain,
  input wire logic [1:0]  converter_ref_gain,
  input wire logic        temp_sense_enable,
  input wire logic        temp_range_select,
  input wire logic        temp_channel_route
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] outs;
  assign wr_hit = psel && penable && pready && pwrite && pstrb[0] &&
                  paddr == 12'h000;
  assign rd_hit = psel && penable && pready && !pwrite && paddr == 12'h000;
  assign outs = {ref_enable, 1'b0, temp_sense_enable, temp_range_select,
                 cmp_dac_ref_gain, converter_ref_gain};
  sequence wr_s;
    wr_hit;
  endsequence
  en_load_a: assert property (
    wr_s |=> outs[7] == $past(pwdata[7]))
    else $error("enable not loaded");
  ts_load_a: assert property (
    wr_s |=> outs[5] == $past(pwdata[5]))
    else $error("sense enable not loaded");
  rng_load_a: assert property (
    wr_s |=> outs[4] == $past(pwdata[4]))
    else $error("range not loaded");
  cmp_gain_a: assert property (
    wr_s |=> outs[3:2] == $past(pwdata[3:2]))
    else $error("cmp gain not loaded");
  conv_gain_a: assert property (
    wr_s |=> outs[1:0] == $past(pwdata[1:0]))
    else $error("conv gain not loaded");
  route_a: assert property (
    temp_channel_route == temp_sense_enable)
    else $error("channel route mismatch");
  outs_hold_a: assert property (
    !wr_hit |=> $stable(outs))
    else $error("outputs moved without write");
  rdy_off_a: assert property (
    rd_hit && !ref_enable && !$past(ref_enable)
    |-> prdata[6] == STANDARD_VARIANT) else $error("ready flag wrong");
endmodule // vrtc_checker
bind vrtc_top vrtc_checker #(.STANDARD_VARIANT(STANDARD_VARIANT)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .ref_enable(ref_enable),
  .cmp_dac_ref_gain(cmp_dac_ref_gain),
  .converter_ref_gain(converter_ref_gain),
  .temp_sense_enable(temp_sense_enable),
  .temp_range_select(temp_range_select),
  .temp_channel_route(temp_channel_route));

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, ref_stable, ref_enable, ts_en, ts_rng, route;
  logic [1:0]  cmp_g, conv_g;
  logic [31:0] std_prdata;
  int          err_count = 0, samples_checked = 0;
  initial forever #2 pclk = ~pclk;
  vrtc_top #(.BUF_SETTLE_CYCLES(16'h0008), .TS_SETTLE_CYCLES(16'h000c)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_stable(ref_stable), .ref_enable(ref_enable),
    .cmp_dac_ref_gain(cmp_g), .converter_ref_gain(conv_g),
    .temp_sense_enable(ts_en), .temp_range_select(ts_rng),
    .temp_channel_route(route));
  vrtc_analog_model u_analog (.pclk(pclk), .presetn(presetn),
    .ref_enable(ref_enable), .ref_stable(ref_stable));
  // standard-voltage variant sees the same bus, only its read data is used
  if (1) begin : g_std
    vrtc_top #(.STANDARD_VARIANT(1'b1), .BUF_SETTLE_CYCLES(16'h0008),
      .TS_SETTLE_CYCLES(16'h000c)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(std_prdata), .pready(), .pslverr(),
      .ref_stable(ref_stable), .ref_enable(),
      .cmp_dac_ref_gain(), .converter_ref_gain(),
      .temp_sense_enable(), .temp_range_select(),
      .temp_channel_route());
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic experr, output logic [31:0] rd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk("slave error", 32'(experr), 32'(pslverr));
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, 4'hf, 1'b0, x);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    apb(1'b0, a, 32'h0000_0000, 4'hf, a > 12'h004, x);
    chk("read data", exp, x);
    if (a == 12'h000) chk("std ready", 32'h1, 32'(std_prdata[6]));
  endtask
  task automatic chk_out(input logic [7:0] v);
    #1;
    chk("outputs", 32'(v & 8'hbf),
        32'({ref_enable, 1'b0, ts_en, ts_rng, cmp_g, conv_g}));
    chk("channel route", 32'(v[5]), 32'(route));
  endtask
  task automatic t_fields;
    logic [7:0] v;
    for (int g = 0; g < 4; g++) begin
      v = (8'(g) * 8'h55) ^ 8'h03;
      wr(12'h000, 32'(v));
      chk_out(v);
      // enabled since the previous pass only when g is 3
      rd_chk(12'h000, 32'((v & 8'hbf) | (g == 3 ? 8'h40 : 8'h00)));
    end
  endtask
  task automatic t_ready;
    wr(12'h000, 32'h0000_0040);
    rd_chk(12'h000, 32'h0000_0000);
    wr(12'h000, 32'h0000_0080);
    rd_chk(12'h000, 32'h0000_0080);
    repeat (12) @(posedge pclk);
    rd_chk(12'h000, 32'h0000_00c0);
  endtask
  task automatic t_status;
    wr(12'h000, 32'h0000_00bf);
    rd_chk(12'h004, 32'h0000_0000);
    repeat (60) @(posedge pclk);
    rd_chk(12'h004, 32'h0000_0007);
    // sensor off restarts the settle window, buffers stay settled
    wr(12'h000, 32'h0000_009f);
    rd_chk(12'h004, 32'h0000_0003);
    wr(12'h000, 32'h0000_00bf);
  endtask
  task automatic t_refuse;
    logic [31:0] x;
    apb(1'b1, 12'h000, 32'h0000_0000, 4'h0, 1'b0, x);
    chk_out(8'hbf);
    apb(1'b1, 12'h008, 32'h0000_0000, 4'hf, 1'b1, x);
    chk_out(8'hbf);
    rd_chk(12'h008, 32'h0000_0000);
  endtask
  task automatic t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_out(8'h00);
    presetn <= 1'b1;
    rd_chk(12'h000, 32'h0000_0000);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h000, 32'h0000_0000);
    t_fields();
    t_ready();
    t_status();
    t_refuse();
    t_midreset();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    end_sim();
  end
endmodule // testbench
